// ---- logic/pcg_gate_cell.sv ----
// pcg_gate_cell: glitch-free clock gate for one peripheral clock.
// assumes enable is a core_clk register; latch is transparent while the clock is low.
`timescale 1ns/1ns
module pcg_gate_cell (
  input  wire logic clk,
  input  wire logic en,
  output      logic gclk
);
  logic en_lat;

  // enable can only change while clk is low, so no shortened high phase
  always_latch begin
    if (!clk) begin
      en_lat = en;
    end
  end

  assign gclk = clk & en_lat;
endmodule

// ---- logic/pcg_top.sv ----
// pcg_top: run, sleep and deep-sleep clock gating registers with per-unit clock enables,
// peripheral enables, bus fault detection and a fault interrupt.
// assumes a single-cycle register port on core_clk and a power mode input from the core.
//
// Overview of operation
// - gating bit one gives the unit its clock and lets it run.
// - gating bit zero stops the unit's clock and holds it disabled.
// - any access to an unclocked unit is answered with a bus fault.
// - all gating bits reset to zero, every unit starts unclocked.
// - separate gating sets for run, sleep and deep-sleep operation.
// - sleep and deep sets apply only with auto gating select set.
// - group-1: bit 24 comparator, bits 18,17,16 counters two, one, zero.
// - group-1: bit 4 sync serial, bit 1 serial one, bit 0 serial zero.
`timescale 1ns/1ns
module pcg_top
  import pcg_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic [PCG_AW-1:0]   reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output      logic [31:0]         reg_rdata,
  input  wire logic [1:0]          power_mode,
  input  wire logic                periph_access,
  input  wire logic [3:0]          periph_sel,
  output      logic                periph_bus_fault,
  output      logic [PCG_NUNITS-1:0] unit_enable,
  output      logic [PCG_NUNITS-1:0] unit_gclk,
  output      logic                irq
);
  logic [31:0] run_gate_group0_q;
  logic [31:0] run_gate_group1_q;
  logic [31:0] sleep_gate_group0_q;
  logic [31:0] sleep_gate_group1_q;
  logic [31:0] deep_sleep_gate_group0_q;
  logic [31:0] deep_sleep_gate_group1_q;
  logic [31:0] run_clock_config_q;
  logic [1:0]  int_status_q;
  logic [1:0]  int_mask_q;
  logic [3:0]  fault_unit_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [PCG_NUNITS-1:0] unit_en_q;
  logic [PCG_NUNITS-1:0] unit_en_d;
  logic        fault_q;
  logic        irq_q;
  logic [1:0]  mode_s1_q;
  logic [1:0]  mode_s2_q;

  // pack one set's two gating groups into the unit vector order
  function automatic logic [PCG_NUNITS-1:0] pcg_units(input logic [31:0] g0,
                                                       input logic [31:0] g1);
    logic [PCG_NUNITS-1:0] u;
    u = PCG_UNITS_RST;
    u[PCG_U_WDOG] = g0[3];
    u[PCG_U_CONV] = g0[16];
    u[PCG_U_PWM]  = g0[20];
    u[PCG_U_SER0] = g1[0];
    u[PCG_U_SER1] = g1[1];
    u[PCG_U_SYNC] = g1[4];
    u[PCG_U_CNT0] = g1[16];
    u[PCG_U_CNT1] = g1[17];
    u[PCG_U_CNT2] = g1[18];
    u[PCG_U_CMP0] = g1[24];
    return u;
  endfunction

  // write decode, one strobe per writable register; the fault address register has none
  wire         wr_run0   = reg_wr && (reg_addr == PCG_OFF_RUN_GATE_G0);
  wire         wr_run1   = reg_wr && (reg_addr == PCG_OFF_RUN_GATE_G1);
  wire         wr_slp0   = reg_wr && (reg_addr == PCG_OFF_SLEEP_GATE_G0);
  wire         wr_slp1   = reg_wr && (reg_addr == PCG_OFF_SLEEP_GATE_G1);
  wire         wr_deep0  = reg_wr && (reg_addr == PCG_OFF_DEEP_GATE_G0);
  wire         wr_deep1  = reg_wr && (reg_addr == PCG_OFF_DEEP_GATE_G1);
  wire         wr_cfg    = reg_wr && (reg_addr == PCG_OFF_RUN_CLK_CFG);
  wire         wr_stat   = reg_wr && (reg_addr == PCG_OFF_INT_STATUS);
  wire         wr_mask   = reg_wr && (reg_addr == PCG_OFF_INT_MASK);
  wire         auto_gating_select = run_clock_config_q[PCG_AUTO_GATING_BIT];
  wire [1:0]   mode      = mode_s2_q;

  // mode selection: without auto gating select the run set always governs
  wire [PCG_NUNITS-1:0] run_units  = pcg_units(run_gate_group0_q, run_gate_group1_q);
  wire [PCG_NUNITS-1:0] slp_units  = pcg_units(sleep_gate_group0_q, sleep_gate_group1_q);
  wire [PCG_NUNITS-1:0] deep_units = pcg_units(deep_sleep_gate_group0_q,
                                               deep_sleep_gate_group1_q);
  wire use_sleep = auto_gating_select && (mode == PCG_MODE_SLEEP);
  wire use_deep  = auto_gating_select && (mode == PCG_MODE_DEEP);
  assign unit_en_d = use_deep ? deep_units : (use_sleep ? slp_units : run_units);

  // access to a unit whose enable is low faults instead of completing
  wire sel_valid = periph_sel < 4'(PCG_NUNITS);
  wire sel_en    = sel_valid ? unit_en_q[periph_sel] : 1'b0;
  wire fault_now = periph_access && !sel_en;
  wire bad_reg   = (reg_wr || reg_rd) && !(wr_run0 || wr_run1 || wr_slp0 || wr_slp1 ||
                   wr_deep0 || wr_deep1 || wr_cfg || wr_stat || wr_mask ||
                   (reg_rd && (reg_addr == PCG_OFF_RUN_GATE_G0 ||
                    reg_addr == PCG_OFF_RUN_GATE_G1 || reg_addr == PCG_OFF_SLEEP_GATE_G0 ||
                    reg_addr == PCG_OFF_SLEEP_GATE_G1 || reg_addr == PCG_OFF_DEEP_GATE_G0 ||
                    reg_addr == PCG_OFF_DEEP_GATE_G1 || reg_addr == PCG_OFF_RUN_CLK_CFG ||
                    reg_addr == PCG_OFF_INT_STATUS || reg_addr == PCG_OFF_INT_MASK ||
                    reg_addr == PCG_OFF_FAULT_ADDR)));
  wire [1:0] events = {bad_reg, fault_now};

  // read decode; reserved bits read zero since they are never stored
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == PCG_OFF_RUN_GATE_G0) begin
      rdata_d = run_gate_group0_q;
    end else if (reg_addr == PCG_OFF_RUN_GATE_G1) begin
      rdata_d = run_gate_group1_q;
    end else if (reg_addr == PCG_OFF_SLEEP_GATE_G0) begin
      rdata_d = sleep_gate_group0_q;
    end else if (reg_addr == PCG_OFF_SLEEP_GATE_G1) begin
      rdata_d = sleep_gate_group1_q;
    end else if (reg_addr == PCG_OFF_DEEP_GATE_G0) begin
      rdata_d = deep_sleep_gate_group0_q;
    end else if (reg_addr == PCG_OFF_DEEP_GATE_G1) begin
      rdata_d = deep_sleep_gate_group1_q;
    end else if (reg_addr == PCG_OFF_RUN_CLK_CFG) begin
      rdata_d = run_clock_config_q;
    end else if (reg_addr == PCG_OFF_INT_STATUS) begin
      rdata_d = {30'h0, int_status_q};
    end else if (reg_addr == PCG_OFF_INT_MASK) begin
      rdata_d = {30'h0, int_mask_q};
    end else if (reg_addr == PCG_OFF_FAULT_ADDR) begin
      rdata_d = {28'h0, fault_unit_q};
    end
  end

  // gating registers: only documented bits are writable, all reset to zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      run_gate_group0_q        <= PCG_GATE_RST;
      run_gate_group1_q        <= PCG_GATE_RST;
      sleep_gate_group0_q      <= PCG_GATE_RST;
      sleep_gate_group1_q      <= PCG_GATE_RST;
      deep_sleep_gate_group0_q <= PCG_GATE_RST;
      deep_sleep_gate_group1_q <= PCG_GATE_RST;
      run_clock_config_q       <= PCG_CFG_RST;
    end else begin
      if (wr_run0)  run_gate_group0_q        <= reg_wdata & PCG_G0_WMASK;
      if (wr_run1)  run_gate_group1_q        <= reg_wdata & PCG_G1_WMASK;
      if (wr_slp0)  sleep_gate_group0_q      <= reg_wdata & PCG_G0_WMASK;
      if (wr_slp1)  sleep_gate_group1_q      <= reg_wdata & PCG_G1_WMASK;
      if (wr_deep0) deep_sleep_gate_group0_q <= reg_wdata & PCG_G0_WMASK;
      if (wr_deep1) deep_sleep_gate_group1_q <= reg_wdata & PCG_G1_WMASK;
      if (wr_cfg)   run_clock_config_q       <= reg_wdata & (32'h1 << PCG_AUTO_GATING_BIT);
    end
  end

  // sticky status: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_status_q <= 2'h0;
      int_mask_q   <= PCG_INT_MASK_RST;
      fault_unit_q <= 4'h0;
    end else begin
      int_status_q <= (int_status_q & ~(wr_stat ? reg_wdata[1:0] : 2'h0)) | events;
      if (wr_mask) int_mask_q <= reg_wdata[1:0];
      if (fault_now) fault_unit_q <= periph_sel;
    end
  end

  // power mode comes from the core's sleep logic on another path; synchronise it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
    end else begin
      mode_s1_q <= power_mode;
      mode_s2_q <= mode_s1_q;
    end
  end

  // enables registered so the gate cells only ever see a core_clk-aligned change
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      unit_en_q <= PCG_UNITS_RST;
      fault_q   <= 1'b0;
      irq_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      unit_en_q <= unit_en_d;
      fault_q   <= fault_now;
      irq_q     <= |(((int_status_q & ~(wr_stat ? reg_wdata[1:0] : 2'h0)) | events)
                     & int_mask_q);
      rdata_q   <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

  // one glitch-free gate per unit; disabled units get no clock edges
  for (genvar i = 0; i < PCG_NUNITS; i++) begin : g_gate
    pcg_gate_cell u_gate (
      .clk  (core_clk),
      .en   (unit_en_q[i]),
      .gclk (unit_gclk[i])
    );
  end

  assign unit_enable      = unit_en_q;
  assign periph_bus_fault = fault_q;
  assign irq              = irq_q;
  assign reg_rdata        = rdata_q;
endmodule

// ---- pkg/pcg_pkg.sv ----
// pcg_pkg: register map, field positions and reset values of the clock gating block.
// assumes a 32-bit register port and a single system clock domain.
package pcg_pkg;
  localparam int          PCG_AW                = 12;
  localparam logic [11:0] PCG_OFF_RUN_GATE_G0   = 12'h100;
  localparam logic [11:0] PCG_OFF_RUN_GATE_G1   = 12'h104;
  localparam logic [11:0] PCG_OFF_SLEEP_GATE_G0 = 12'h110;
  localparam logic [11:0] PCG_OFF_SLEEP_GATE_G1 = 12'h114;
  localparam logic [11:0] PCG_OFF_DEEP_GATE_G0  = 12'h120;
  localparam logic [11:0] PCG_OFF_DEEP_GATE_G1  = 12'h124;
  localparam logic [11:0] PCG_OFF_RUN_CLK_CFG   = 12'h060;
  localparam logic [11:0] PCG_OFF_INT_STATUS    = 12'h180;
  localparam logic [11:0] PCG_OFF_INT_MASK      = 12'h184;
  localparam logic [11:0] PCG_OFF_FAULT_ADDR    = 12'h188;
  localparam int          PCG_AUTO_GATING_BIT   = 27;
  localparam logic [31:0] PCG_G0_WMASK          = 32'h0011_0008;
  localparam logic [31:0] PCG_G1_WMASK          = 32'h0107_0013;
  localparam int          PCG_NUNITS            = 10;
  localparam logic [31:0] PCG_GATE_RST          = 32'h0000_0000;
  localparam logic [31:0] PCG_CFG_RST           = 32'h0000_0000;
  localparam int          PCG_INT_FAULT_BIT     = 0;
  localparam int          PCG_INT_BADREG_BIT    = 1;
  localparam logic [1:0]  PCG_INT_MASK_RST      = 2'h0;
  localparam logic [9:0]  PCG_UNITS_RST         = 10'h000;
  // unit index order of the per-unit enable vector
  localparam int PCG_U_WDOG = 0;
  localparam int PCG_U_CONV = 1;
  localparam int PCG_U_PWM  = 2;
  localparam int PCG_U_SER0 = 3;
  localparam int PCG_U_SER1 = 4;
  localparam int PCG_U_SYNC = 5;
  localparam int PCG_U_CNT0 = 6;
  localparam int PCG_U_CNT1 = 7;
  localparam int PCG_U_CNT2 = 8;
  localparam int PCG_U_CMP0 = 9;
  typedef enum logic [1:0] {
    PCG_MODE_RUN   = 2'h0,
    PCG_MODE_SLEEP = 2'h1,
    PCG_MODE_DEEP  = 2'h3
  } pcg_mode_t;
endpackage

// ---- verification/pcg_props.sv ----
// pcg_props: port-level checks of the clock gating block.
// assumes it is bound to pcg_top and sees only that module's ports.
`timescale 1ns/1ns
module pcg_props
  import pcg_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire logic [PCG_AW-1:0]      reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  input wire logic [1:0]             power_mode,
  input wire logic                   periph_access,
  input wire logic [3:0]             periph_sel,
  input wire logic                   periph_bus_fault,
  input wire logic [PCG_NUNITS-1:0]  unit_enable,
  input wire logic [PCG_NUNITS-1:0]  unit_gclk,
  input wire logic                   irq
);
  // index range tested first so an out-of-range select never reads the vector
  wire bad_acc = periph_access && (periph_sel > 4'h9 || !unit_enable[periph_sel]);

  rst_clear_a: assert property (@(posedge core_clk) sys_rst |=>
    unit_enable == PCG_UNITS_RST && !irq && !periph_bus_fault) else $error("reset left state");
  fault_taken_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bad_acc |=> periph_bus_fault) else $error("missing bus fault");
  no_fault_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bad_acc |=> !periph_bus_fault) else $error("spurious bus fault");
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside its cycle");
  g0_reserved_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == PCG_OFF_DEEP_GATE_G0 |=> (reg_rdata & ~PCG_G0_WMASK) == 32'h0)
    else $error("group0 reserved bit set");
  g1_reserved_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == PCG_OFF_RUN_GATE_G1 |=> (reg_rdata & ~PCG_G1_WMASK) == 32'h0)
    else $error("group1 reserved bit set");
  gclk_follow_a: assert property (@(negedge core_clk) disable iff (sys_rst)
    $stable(unit_enable) |-> unit_gclk == unit_enable) else $error("gated clock mismatch");
  en_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(unit_enable) |-> $past(reg_wr, 2) || $past(power_mode, 1) != $past(power_mode, 5))
    else $error("enable changed without cause");
endmodule

bind pcg_top pcg_props u_props (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .power_mode, .periph_access, .periph_sel, .periph_bus_fault,
  .unit_enable, .unit_gclk, .irq);

// ---- verification/test_peripheral_clock_gating.sv ----
// test_peripheral_clock_gating: self-checking bench for pcg_top.
// assumes pcg_props is bound to the design; one 20 MHz clock.
`timescale 1ns/1ns
module test_peripheral_clock_gating
  import pcg_pkg::*;
;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
  typedef struct packed {logic [11:0] a; logic [31:0] d, rb; logic [9:0] en;} pcg_row_t;
  logic        core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        periph_access = 1'b0, periph_bus_fault, irq;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic [1:0]  power_mode = 2'h0;
  logic [3:0]  periph_sel = 4'h0;
  logic [9:0]  unit_enable, unit_gclk;
  int          fail_count = 0, samples_checked = 0, cyc = 0;
  logic [11:0] offs [6] = '{12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124};
  // later rows lean on what earlier rows left in the other registers
  pcg_row_t    rows [11] = '{
    '{12'h104, 32'hffff_ffff, 32'h0107_0013, 10'h3f8},
    '{12'h100, 32'hffff_ffff, 32'h0011_0008, 10'h3ff},
    '{12'h100, 32'h0000_0008, 32'h0000_0008, 10'h3f9},
    '{12'h100, 32'h0001_0000, 32'h0001_0000, 10'h3fa},
    '{12'h100, 32'h0010_0000, 32'h0010_0000, 10'h3fc},
    '{12'h104, 32'h0004_0012, 32'h0004_0012, 10'h134},
    '{12'h104, 32'h0103_0001, 32'h0103_0001, 10'h2cc},
    '{12'h110, 32'hffff_ffff, 32'h0011_0008, 10'h2cc},
    '{12'h114, 32'h0000_0013, 32'h0000_0013, 10'h2cc},
    '{12'h124, 32'hffff_ffff, 32'h0107_0013, 10'h2cc},
    '{12'h120, 32'h0010_0000, 32'h0010_0000, 10'h2cc}};

  pcg_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_mode(power_mode),
    .periph_access(periph_access), .periph_sel(periph_sel), .periph_bus_fault(periph_bus_fault),
    .unit_enable(unit_enable), .unit_gclk(unit_gclk), .irq(irq));

  always #25 core_clk = ~core_clk;

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic acc(input logic [3:0] s);
    @(posedge core_clk);
    periph_sel <= s;
    periph_access <= 1'b1;
    @(posedge core_clk);
    periph_access <= 1'b0;
    #1;
  endtask
  // mode input is synchronised, so give it more than the three cycles it needs
  task automatic mode(input logic [1:0] m);
    @(posedge core_clk);
    power_mode <= m;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task test_done;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    `CHK("enable rst", 10'h000, unit_enable)
    foreach (offs[i]) begin
      rd(offs[i]);
      `CHK("gate rst", 32'h0, rv)
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK("readback", rows[i].rb, rv)
      `CHK("enables", rows[i].en, unit_enable)
    end
    mode(2'h1);
    `CHK("no auto", 10'h2cc, unit_enable)
    wr(PCG_OFF_RUN_CLK_CFG, 32'h0800_0000);
    mode(2'h3);
    `CHK("deep set", 10'h3fc, unit_enable)
    mode(2'h1);
    `CHK("sleep set", 10'h03f, unit_enable)
    mode(2'h0);
    `CHK("run set", 10'h2cc, unit_enable)
    wr(PCG_OFF_INT_MASK, 32'h1);
    acc(4'h3);
    `CHK("fault on", 1'b0, periph_bus_fault)
    acc(4'h4);
    `CHK("fault off", 1'b1, periph_bus_fault)
    `CHK("irq", 1'b1, irq)
    rd(PCG_OFF_FAULT_ADDR);
    `CHK("fault unit", 4'h4, rv[3:0])
    wr(PCG_OFF_INT_STATUS, 32'h1);
    rd(PCG_OFF_INT_STATUS);
    `CHK("irq clr", 1'b0, irq)
    wr(PCG_OFF_INT_MASK, 32'h0);
    acc(4'ha);
    `CHK("fault idx", 1'b1, periph_bus_fault)
    `CHK("irq mask", 1'b0, irq)
    rd(12'h200);
    `CHK("unmapped", 32'h0, rv)
    rd(PCG_OFF_INT_STATUS);
    `CHK("status", 32'h0000_0003, rv)
    @(posedge core_clk);
    #10 `CHK("gclk on", 2'b01, unit_gclk[4:3])
    @(negedge core_clk);
    #10 `CHK("gclk low", 1'b0, unit_gclk[3])
    // software keeps the other bits of the register as it found them
    rd(PCG_OFF_RUN_GATE_G1);
    wr(PCG_OFF_RUN_GATE_G1, rv | 32'h0000_0002);
    rd(PCG_OFF_RUN_GATE_G1);
    `CHK("rmw keep", 32'h0103_0003, rv)
    `CHK("rmw enable", 10'h2dc, unit_enable)
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1 `CHK("mid rst", 10'h000, unit_enable)
    test_done();
  end
endmodule
